// >>> verilog/fups_top.sv
// APB front end of the user-mode flash sequencer.
//
// Overview of operation
// - Unlock key enables user program mode.
// - Writing zero to unlock leaves user mode.
// - Erase command in user mode erases sector.
// - Erase status bit set means erase failed.
// - Enabled interrupt stops an erase in progress.
// - Program command arms one byte store.
// - Program single bytes into erased sectors only; here only the selected sector is enforced, not whether it was erased.
// - Flash address comes from register pair.
// - Upper nibble lock pattern enables hard lock.
// - Lock command accepted only in user mode.
// - Hard lock refuses every write and erase.
// - Only a tool chip erase releases lock; here a reset also clears it.
// - Writing zero to control cancels armed operations.
// - Sector base from high byte plus bit seven.
// - Control bit zero starts the operation.
// - Reserved boot area refuses erase and program.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "fups_regs.svh"
module fups_top
    import fups_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] irq_pending,
    input wire logic [7:0] periph_irq_enable,
    input wire logic tool_chip_erase,
    input wire logic [2:0] boot_reserve_size,
    output logic flash_erase_req,
    output logic flash_prog_req,
    output logic flash_read_req,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wdata,
    input wire logic flash_done,
    input wire logic flash_fail,
    input wire logic [7:0] flash_rdata
);
    // ------------------------------------------------------------------
    // Registers and helpers
    // ------------------------------------------------------------------
    logic [7:0] unlock_reg;
    logic [3:0] op_reg;
    logic erase_fail_reg;
    logic prog_armed_reg;
    logic lock_reg;
    logic [7:0] sech_reg;
    logic [7:0] secl_reg;
    logic [7:0] pmah_reg;
    logic [7:0] pmal_reg;
    logic [7:0] imask_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic wait_reg;
    logic start_erase_reg;
    logic start_prog_reg;
    logic start_read_reg;
    logic [15:0] op_addr_reg;
    logic [7:0] wdata_reg;
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic user_mode;
    logic acc;
    logic wr_ctrl;
    logic ctrl_start;
    logic flash_addr_hit;
    logic [15:0] pm_addr;
    logic [15:0] sec_base;
    logic erase_ok;
    logic prog_ok;

    fups_seq_if sq();

    fups_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .s(sq.seq)
    );

    // Address lies in the reserved boot area.
    function automatic logic in_reserved(input logic [15:0] a, input logic [2:0] opt);
        logic [15:0] top_addr;
        top_addr = `FUPS_RSV_END0;
        case (opt[1:0])
            2'h1: top_addr = `FUPS_RSV_END1;
            2'h2: top_addr = `FUPS_RSV_END2;
            2'h3: top_addr = `FUPS_RSV_END3;
            default: top_addr = `FUPS_RSV_END0;
        endcase
        in_reserved = !opt[`FUPS_RSV_OFF] && a >= `FUPS_RSV_BASE && a <= top_addr;
    endfunction : in_reserved

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Option and tool erase pins pass two flops before use.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end else begin
            pin_meta_reg <= {tool_chip_erase, boot_reserve_size};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign user_mode = (unlock_reg == `FUPS_KEY);
    assign acc = psel && penable && !pready_reg && !wait_reg;
    assign wr_ctrl = acc && pwrite && paddr == `FUPS_OFF_CTRL;
    assign ctrl_start = pwdata[`FUPS_BIT_START];
    assign flash_addr_hit = paddr == `FUPS_OFF_PMDATA || paddr == `FUPS_OFF_CTRL;
    assign pm_addr = {pmah_reg, pmal_reg};
    assign sec_base = {sech_reg, secl_reg[`FUPS_SEC_BIT], 7'h00};
    assign erase_ok = !lock_reg && !in_reserved(sec_base, pin_sync_reg[2:0]);
    assign prog_ok = prog_armed_reg && user_mode && !lock_reg
        && pm_addr[15:7] == sec_base[15:7]
        && !in_reserved(pm_addr, pin_sync_reg[2:0]);
    assign sq.start_erase = start_erase_reg;
    assign sq.start_prog = start_prog_reg;
    assign sq.start_read = start_read_reg;
    assign sq.addr = op_addr_reg;
    assign sq.wdata = wdata_reg;
    assign sq.abort = |(irq_pending & imask_reg & periph_irq_enable);
    assign sq.flash_done = flash_done;
    assign sq.flash_fail = flash_fail;
    assign sq.flash_rdata = flash_rdata;
    assign flash_erase_req = sq.flash_erase_req;
    assign flash_prog_req = sq.flash_prog_req;
    assign flash_read_req = sq.flash_read_req;
    assign flash_addr = sq.flash_addr;
    assign flash_wdata = sq.flash_wdata;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------
    // Flash accesses stall until the sequencer is idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            wait_reg <= 1'b0;
            start_prog_reg <= 1'b0;
            start_read_reg <= 1'b0;
        end else begin
            start_prog_reg <= 1'b0;
            start_read_reg <= 1'b0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            if (wait_reg) begin
                if (sq.done) begin
                    wait_reg <= 1'b0;
                    pready_reg <= 1'b1;
                    prdata_reg <= {24'h000000, sq.rdata};
                end
            end else if (acc && !(flash_addr_hit && sq.busy)) begin
                prdata_reg <= 32'h0000_0000;
                if (paddr == `FUPS_OFF_PMDATA && pwrite && prog_ok) begin
                    start_prog_reg <= 1'b1;
                    wait_reg <= 1'b1;
                end else if (paddr == `FUPS_OFF_PMDATA && !pwrite) begin
                    start_read_reg <= 1'b1;
                    wait_reg <= 1'b1;
                end else begin
                    pready_reg <= 1'b1;
                    if (paddr == `FUPS_OFF_UNLOCK) begin
                        prdata_reg <= {24'h000000, unlock_reg};
                    end else if (paddr == `FUPS_OFF_CTRL) begin
                        prdata_reg <= {24'h000000, op_reg, erase_fail_reg, 2'b00, sq.busy};
                    end else if (paddr == `FUPS_OFF_SECH) begin
                        prdata_reg <= {24'h000000, sech_reg};
                    end else if (paddr == `FUPS_OFF_SECL) begin
                        prdata_reg <= {24'h000000, secl_reg};
                    end else if (paddr == `FUPS_OFF_PMAH) begin
                        prdata_reg <= {24'h000000, pmah_reg};
                    end else if (paddr == `FUPS_OFF_PMAL) begin
                        prdata_reg <= {24'h000000, pmal_reg};
                    end else if (paddr == `FUPS_OFF_STATUS) begin
                        prdata_reg <= {28'h0000000, lock_reg, prog_armed_reg, user_mode, sq.busy};
                    end else if (paddr == `FUPS_OFF_IMASK) begin
                        prdata_reg <= {24'h000000, imask_reg};
                    end else if (paddr != `FUPS_OFF_PMDATA) begin
                        pslverr_reg <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Plain storage registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_reg <= 8'h00;
            sech_reg <= 8'h00;
            secl_reg <= 8'h00;
            pmah_reg <= 8'h00;
            pmal_reg <= 8'h00;
            imask_reg <= 8'h00;
        end else if (acc && pwrite) begin
            if (paddr == `FUPS_OFF_UNLOCK) begin
                unlock_reg <= pwdata[7:0];
            end else if (paddr == `FUPS_OFF_SECH) begin
                sech_reg <= pwdata[7:0];
            end else if (paddr == `FUPS_OFF_SECL) begin
                secl_reg <= pwdata[7:0];
            end else if (paddr == `FUPS_OFF_PMAH) begin
                pmah_reg <= pwdata[7:0];
            end else if (paddr == `FUPS_OFF_PMAL) begin
                pmal_reg <= pwdata[7:0];
            end else if (paddr == `FUPS_OFF_IMASK) begin
                imask_reg <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Control register, erase launch and status
    // ------------------------------------------------------------------
    // Control writes outside user mode are dropped except zero, which still cancels; a busy sequencer stalls them instead.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_reg <= `FUPS_OP_NONE;
            prog_armed_reg <= 1'b0;
            start_erase_reg <= 1'b0;
            erase_fail_reg <= 1'b0;
            op_addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
        end else begin
            start_erase_reg <= 1'b0;
            if (sq.done && sq.in_erase) begin
                erase_fail_reg <= sq.fail;
            end
            if (wr_ctrl && !sq.busy && user_mode) begin
                op_reg <= pwdata[7:4];
                prog_armed_reg <= 1'b0;
                if (pwdata[7:0] == `FUPS_ZERO8) begin
                    op_reg <= `FUPS_OP_NONE;
                end else if (pwdata[7:4] == `FUPS_OP_ERASE && ctrl_start) begin
                    op_addr_reg <= sec_base;
                    start_erase_reg <= erase_ok;
                    erase_fail_reg <= !erase_ok;
                end else if (pwdata[7:4] == `FUPS_OP_PROG && ctrl_start) begin
                    prog_armed_reg <= 1'b1;
                end
            end else if (wr_ctrl && pwdata[7:0] == `FUPS_ZERO8 && !sq.busy) begin
                op_reg <= `FUPS_OP_NONE;
                prog_armed_reg <= 1'b0;
            end else if (acc && pwrite && paddr == `FUPS_OFF_PMDATA && !sq.busy) begin
                prog_armed_reg <= 1'b0;
                op_addr_reg <= pm_addr;
                wdata_reg <= pwdata[7:0];
            end else if (acc && !pwrite && paddr == `FUPS_OFF_PMDATA && !sq.busy) begin
                op_addr_reg <= pm_addr;
            end
        end
    end

    // ------------------------------------------------------------------
    // Hard lock
    // ------------------------------------------------------------------
    // Only the tool chip erase pin or a reset clears the lock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_reg <= 1'b0;
        end else if (pin_sync_reg[3]) begin
            lock_reg <= 1'b0;
        end else if (wr_ctrl && !sq.busy && user_mode && pwdata[7:4] == `FUPS_OP_LOCK) begin
            lock_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ctrl_wr(logic [7:0] v);
        wr_ctrl && pwdata[7:0] == v && !sq.busy;
    endsequence

    sequence s_erase_run;
        start_erase_reg ##1 sq.in_erase;
    endsequence

    chk_unlock_enter: assert property (acc && pwrite && paddr == `FUPS_OFF_UNLOCK
        && pwdata[7:0] == `FUPS_KEY |=> user_mode)
        else $error("Key did not enable user mode.");
    chk_unlock_leave: assert property (acc && pwrite && paddr == `FUPS_OFF_UNLOCK
        && pwdata[7:0] == `FUPS_ZERO8 |=> !user_mode)
        else $error("Zero did not leave user mode.");
    chk_erase_launch: assert property (s_ctrl_wr(8'hA1) ##0 user_mode && erase_ok
        |=> s_erase_run)
        else $error("Erase did not start.");
    chk_erase_status: assert property (sq.done && sq.in_erase |=> erase_fail_reg == $past(sq.fail))
        else $error("Erase status wrong.");
    chk_prog_single: assert property (start_prog_reg |-> !prog_armed_reg ##1 sq.busy)
        else $error("Arm not consumed.");
    chk_lock_refuse: assert property (lock_reg |-> !start_erase_reg && !start_prog_reg)
        else $error("Launch under lock.");
    chk_lock_persist: assert property (lock_reg && !pin_sync_reg[3] |=> lock_reg)
        else $error("Lock released.");
    chk_ctrl_cancel: assert property (s_ctrl_wr(8'h00) |=> op_reg == `FUPS_OP_NONE
        && !prog_armed_reg)
        else $error("Cancel failed.");
    chk_reserved_block: assert property (start_prog_reg |-> !in_reserved(op_addr_reg,
        pin_sync_reg[2:0]))
        else $error("Store into reserved area.");
endmodule : fups_top

// >>> verilog/fups_regs.svh
// Offsets, command codes and field positions of the sequencer.
`ifndef FUPS_REGS_SVH
`define FUPS_REGS_SVH
`define FUPS_OFF_UNLOCK 8'h00
`define FUPS_OFF_CTRL 8'h04
`define FUPS_OFF_SECH 8'h08
`define FUPS_OFF_SECL 8'h0C
`define FUPS_OFF_PMAH 8'h10
`define FUPS_OFF_PMAL 8'h14
`define FUPS_OFF_PMDATA 8'h18
`define FUPS_OFF_STATUS 8'h1C
`define FUPS_OFF_IMASK 8'h20
`define FUPS_KEY 8'hA5
`define FUPS_ZERO8 8'h00
`define FUPS_OP_ERASE 4'hA
`define FUPS_OP_PROG 4'h5
`define FUPS_OP_LOCK 4'h6
`define FUPS_OP_NONE 4'h0
`define FUPS_BIT_START 0
`define FUPS_SEC_BIT 7
`define FUPS_RSV_BASE 16'h0100
`define FUPS_RSV_END0 16'h01FF
`define FUPS_RSV_END1 16'h02FF
`define FUPS_RSV_END2 16'h04FF
`define FUPS_RSV_END3 16'h08FF
`define FUPS_RSV_OFF 2
`endif

// >>> verilog/fups_pkg.sv
// Types shared by the flash sequencer modules.
package fups_pkg;
    typedef enum logic [1:0] {
        FUPS_IDLE,
        FUPS_ERASE,
        FUPS_PROG,
        FUPS_READ
    } fups_state_t;
endpackage : fups_pkg

// >>> verilog/fups_seq_if.sv
// Signals between the front end and the sequencer.
`timescale 1ns/1ps
interface fups_seq_if;
    logic start_erase;
    logic start_prog;
    logic start_read;
    logic abort;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic busy;
    logic in_erase;
    logic done;
    logic fail;
    logic [7:0] rdata;
    logic flash_erase_req;
    logic flash_prog_req;
    logic flash_read_req;
    logic [15:0] flash_addr;
    logic [7:0] flash_wdata;
    logic flash_done;
    logic flash_fail;
    logic [7:0] flash_rdata;
    modport ctl (output start_erase, output start_prog, output start_read, output abort,
        output addr, output wdata, input busy, input in_erase, input done, input fail,
        input rdata, input flash_erase_req, input flash_prog_req, input flash_read_req,
        input flash_addr, input flash_wdata, output flash_done, output flash_fail,
        output flash_rdata);
    modport seq (input start_erase, input start_prog, input start_read, input abort,
        input addr, input wdata, output busy, output in_erase, output done, output fail,
        output rdata, output flash_erase_req, output flash_prog_req, output flash_read_req,
        output flash_addr, output flash_wdata, input flash_done, input flash_fail,
        input flash_rdata);
endinterface : fups_seq_if

// >>> verilog/fups_seq.sv
// Flash array sequencer: runs one erase, program or read at a time.
`timescale 1ns/1ps
`include "fups_regs.svh"
module fups_seq
    import fups_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    fups_seq_if.seq s
);
    fups_state_t state_reg;
    logic erase_req_reg;
    logic prog_req_reg;
    logic read_req_reg;
    logic [15:0] addr_reg;
    logic [7:0] wdata_reg;
    logic done_reg;
    logic fail_reg;
    logic [7:0] rdata_reg;
    logic erase_end_reg;

    assign s.busy = (state_reg != FUPS_IDLE);
    // Erase stays flagged in the done cycle so the status bit can catch the outcome.
    assign s.in_erase = (state_reg == FUPS_ERASE) || erase_end_reg;
    assign s.done = done_reg;
    assign s.fail = fail_reg;
    assign s.rdata = rdata_reg;
    assign s.flash_erase_req = erase_req_reg;
    assign s.flash_prog_req = prog_req_reg;
    assign s.flash_read_req = read_req_reg;
    assign s.flash_addr = addr_reg;
    assign s.flash_wdata = wdata_reg;

    // Requests are held as levels until the array reports completion; an erase request also drops on abort.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= FUPS_IDLE;
            erase_req_reg <= 1'b0;
            prog_req_reg <= 1'b0;
            read_req_reg <= 1'b0;
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            rdata_reg <= 8'h00;
            erase_end_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            erase_end_reg <= 1'b0;
            case (state_reg)
                FUPS_IDLE: begin
                    addr_reg <= s.addr;
                    wdata_reg <= s.wdata;
                    if (s.start_erase) begin
                        state_reg <= FUPS_ERASE;
                        erase_req_reg <= 1'b1;
                    end else if (s.start_prog) begin
                        state_reg <= FUPS_PROG;
                        prog_req_reg <= 1'b1;
                    end else if (s.start_read) begin
                        state_reg <= FUPS_READ;
                        read_req_reg <= 1'b1;
                    end
                end
                FUPS_ERASE: begin
                    // An enabled interrupt cuts the erase short; the sector counts as failed.
                    if (s.abort || s.flash_done) begin
                        state_reg <= FUPS_IDLE;
                        erase_req_reg <= 1'b0;
                        done_reg <= 1'b1;
                        fail_reg <= s.abort | s.flash_fail;
                        erase_end_reg <= 1'b1;
                    end
                end
                FUPS_PROG: begin
                    if (s.flash_done) begin
                        state_reg <= FUPS_IDLE;
                        prog_req_reg <= 1'b0;
                        done_reg <= 1'b1;
                        fail_reg <= s.flash_fail;
                    end
                end
                default: begin
                    if (s.flash_done) begin
                        state_reg <= FUPS_IDLE;
                        read_req_reg <= 1'b0;
                        done_reg <= 1'b1;
                        fail_reg <= 1'b0;
                        rdata_reg <= s.flash_rdata;
                    end
                end
            endcase
        end
    end

    chk_irq_abort: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == FUPS_ERASE && s.abort) |=> !erase_req_reg && done_reg && fail_reg)
        else $error("Interrupt did not stop erase.");
endmodule : fups_seq

// >>> tb/fups_flash_model.sv
// Behavioural flash array that answers the sequencer's requests.
`timescale 1ns/1ps
module fups_flash_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic erase_req,
    input wire logic prog_req,
    input wire logic read_req,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic fail_erase,
    input wire logic [7:0] delay,
    output logic done,
    output logic fail,
    output logic [7:0] rdata
);
    logic [7:0] mem [logic [15:0]];
    logic [7:0] cnt;
    // Answers delay+1 cycles after a request appears; rdata toggles between answers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
            done <= 1'b0;
            fail <= 1'b0;
            rdata <= 8'h00;
        end else begin
            done <= 1'b0;
            fail <= 1'b0;
            rdata <= ~rdata;
            cnt <= 8'h00;
            if ((erase_req || prog_req || read_req) && !done && cnt != delay) begin
                cnt <= cnt + 8'h01;
            end else if ((erase_req || prog_req || read_req) && !done) begin
                done <= 1'b1;
                fail <= erase_req && fail_erase;
                if (erase_req && !fail_erase) begin
                    for (int i = 0; i < 128; i++) begin
                        mem[{addr[15:7], 7'(i)}] = 8'hFF;
                    end
                end
                // Programming an unerased byte stores zero.
                if (prog_req) begin
                    mem[addr] = mem.exists(addr) ? (mem[addr] & wdata) : 8'h00;
                end
                rdata <= mem.exists(addr) ? mem[addr] : 8'h00;
            end
        end
    end
endmodule : fups_flash_model

// >>> tb/test_flash_user_program_erase_seq.sv
// Self-checking bench for the user-mode flash erase and program sequencer.
`timescale 1ns/1ps
`include "fups_regs.svh"
module test_flash_user_program_erase_seq;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00, irq_pending = 8'h00, periph_irq_enable = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic tool_chip_erase = 0, fail_erase = 0, er_q = 0, pr_q = 0;
    logic [2:0] boot_reserve_size = 3'b100;
    logic erase_req, prog_req, read_req, fdone, ffail;
    logic [15:0] faddr, last_addr;
    logic [7:0] fwdata, frdata, dly = 8'h02;
    int n_fail = 0, num_checks = 0, n_erase = 0, n_prog = 0, e0, p0;
    // ---------------------------------------------------------------
    // Clock, design, flash model and request monitor
    // ---------------------------------------------------------------
    always #12.5 pclk = ~pclk;
    fups_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_pending(irq_pending), .periph_irq_enable(periph_irq_enable),
        .tool_chip_erase(tool_chip_erase), .boot_reserve_size(boot_reserve_size),
        .flash_erase_req(erase_req), .flash_prog_req(prog_req), .flash_read_req(read_req),
        .flash_addr(faddr), .flash_wdata(fwdata), .flash_done(fdone), .flash_fail(ffail),
        .flash_rdata(frdata));
    fups_flash_model flash (.pclk(pclk), .presetn(presetn), .erase_req(erase_req),
        .prog_req(prog_req), .read_req(read_req), .addr(faddr), .wdata(fwdata),
        .fail_erase(fail_erase), .delay(dly), .done(fdone), .fail(ffail), .rdata(frdata));
    // Counts request starts so refused commands show.
    always @(posedge pclk) begin
        if (erase_req === 1'b1 && !er_q) n_erase++;
        if (prog_req === 1'b1 && !pr_q) n_prog++;
        if ((erase_req === 1'b1 && !er_q) || (prog_req === 1'b1 && !pr_q)) last_addr = faddr;
        er_q = (erase_req === 1'b1);
        pr_q = (prog_req === 1'b1);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    // One APB transfer, held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = pslverr ? 32'hFFFFFFFF : prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 8'h00);
    endtask : rd
    // Unlock, load the sector, write control, wait for idle.
    task automatic cmd(input logic [7:0] sh, input logic [7:0] sl, input logic [7:0] c);
        e0 = n_erase;
        p0 = n_prog;
        wr(`FUPS_OFF_UNLOCK, `FUPS_KEY);
        wr(`FUPS_OFF_SECH, sh);
        wr(`FUPS_OFF_SECL, sl);
        wr(`FUPS_OFF_CTRL, c);
        do rd(`FUPS_OFF_STATUS); while (rv[0] !== 1'b0);
    endtask : cmd
    task automatic store(input logic [7:0] ah, input logic [7:0] al, input logic [7:0] d);
        wr(`FUPS_OFF_PMAH, ah);
        wr(`FUPS_OFF_PMAL, al);
        wr(`FUPS_OFF_PMDATA, d);
    endtask : store
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_refuse();
        rd(8'h24);
        chk(rv, 32'hFFFFFFFF);
        wr(`FUPS_OFF_CTRL, 8'hA1);
        wr(`FUPS_OFF_CTRL, 8'h61);
        wr(`FUPS_OFF_UNLOCK, 8'h5A);
        wr(`FUPS_OFF_CTRL, 8'hA1);
        rd(`FUPS_OFF_STATUS);
        chk(rv, 32'h0);
        cmd(8'h10, 8'h00, 8'hA0);
        chk(n_erase, 0);
        rd(`FUPS_OFF_STATUS);
        chk(rv & 32'h2, 32'h2);
        wr(`FUPS_OFF_UNLOCK, 8'h00);
        rd(`FUPS_OFF_STATUS);
        chk(rv & 32'h2, 32'h0);
    endtask : t_refuse
    task automatic t_erase(input logic fl);
        fail_erase <= fl;
        cmd(8'h10, 8'hFF, 8'hA1);
        chk(n_erase - e0, 1);
        chk(last_addr, 32'h1080);
        rd(`FUPS_OFF_CTRL);
        chk(rv & 32'h8, {28'h0, fl, 3'h0});
        wr(`FUPS_OFF_UNLOCK, 8'h00);
        fail_erase <= 1'b0;
    endtask : t_erase
    task automatic t_prog();
        cmd(8'h10, 8'h80, 8'h51);
        store(8'h10, 8'h84, 8'h5A);
        chk(last_addr, 32'h1084);
        store(8'h10, 8'h85, 8'h00);
        chk(n_prog - p0, 1);
        wr(`FUPS_OFF_PMAL, 8'h84);
        rd(`FUPS_OFF_PMDATA);
        chk(rv, 32'h5A);
        wr(`FUPS_OFF_CTRL, 8'h51);
        store(8'h11, 8'h04, 8'h00);
        chk(n_prog - p0, 1);
        wr(`FUPS_OFF_CTRL, 8'h51);
        wr(`FUPS_OFF_CTRL, 8'h00);
        store(8'h10, 8'h86, 8'h00);
        chk(n_prog - p0, 1);
        boot_reserve_size <= 3'b000;
        cmd(8'h01, 8'h80, 8'hA1);
        rd(`FUPS_OFF_CTRL);
        chk({n_erase - e0, rv & 32'h8}, {32'h0, 32'h8});
        cmd(8'h01, 8'h80, 8'h51);
        store(8'h01, 8'h90, 8'h00);
        chk(n_prog - p0, 0);
        boot_reserve_size <= 3'b100;
        wr(`FUPS_OFF_UNLOCK, 8'h00);
    endtask : t_prog
    task automatic t_irq();
        dly <= 8'd80;
        periph_irq_enable <= 8'hFF;
        wr(`FUPS_OFF_IMASK, 8'hFF);
        wr(`FUPS_OFF_UNLOCK, `FUPS_KEY);
        wr(`FUPS_OFF_CTRL, 8'hA1);
        rd(`FUPS_OFF_STATUS);
        chk(rv & 32'h1, 32'h1);
        irq_pending <= 8'h01;
        repeat (10) @(posedge pclk);
        chk(erase_req, 1'b0);
        rd(`FUPS_OFF_CTRL);
        chk(rv & 32'h8, 32'h8);
        irq_pending <= 8'h00;
        dly <= 8'h02;
        wr(`FUPS_OFF_UNLOCK, 8'h00);
    endtask : t_irq
    task automatic t_lock();
        cmd(8'h10, 8'h00, 8'h61);
        wr(`FUPS_OFF_UNLOCK, 8'h00);
        rd(`FUPS_OFF_STATUS);
        chk(rv & 32'h8, 32'h8);
        cmd(8'h10, 8'h80, 8'hA1);
        cmd(8'h10, 8'h80, 8'h51);
        store(8'h10, 8'h88, 8'h00);
        chk({n_erase - e0, n_prog - p0}, 64'h0);
        wr(`FUPS_OFF_CTRL, 8'h00);
        wr(`FUPS_OFF_UNLOCK, 8'h00);
        rd(`FUPS_OFF_STATUS);
        chk(rv & 32'h8, 32'h8);
        tool_chip_erase <= 1'b1;
        repeat (6) @(posedge pclk);
        tool_chip_erase <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(`FUPS_OFF_STATUS);
        chk(rv & 32'h8, 32'h0);
    endtask : t_lock
    // Two-cycle reset, then the scenarios.
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_refuse();
        t_erase(1'b1);
        t_erase(1'b0);
        t_prog();
        t_irq();
        t_lock();
        complete_run();
    end
    // Watchdog far beyond what the scenarios need.
    initial begin
        #1000000;
        n_fail++;
        complete_run();
    end
endmodule : test_flash_user_program_erase_seq
